// ---- rtl/tkdr_core.sv ----
// per-key detection, recalibration, guardband and status logic
`include "tkdr_defs.svh"
`default_nettype none
// Overview of operation
// [R1] time each key's detection; recalibrate when it outlasts negative delay
// [R2] negative delay per key; zero disables long-detection recalibration
// [R3] integrator counts detect samples; touch confirmed at the key's target
// [R4] a non-detect sample before target clears the integrator at once
// [R5] released key counts integrator down to zero before reporting off
// [R6] integrator target zero disables detection; bursts still run
// [R7] integrator target offers sixteen values per key
// [R8] signal above positive threshold for positive delay loads reference; code lowers that threshold by the positive hysteresis
// [R9] positive delay per key; zero disables positive recalibration
// [R10] lock command stores every reference as the locked reference
// [R11] guardbands per direction, 0.1 to 25.5 percent in 0.1 steps
// [R12] guardband zero disables that direction
// [R13] locked and enabled: out-of-band reference sets error bit 2 or 3
// [R14] every guardband violation also shows in the multi-key error field
// [R15] suppression: hide detection if another enabled key deviates more
// [R16] suppression compares all enabled keys, enabled per key
// [R17] full recalibration command recalibrates one key or all keys
// [R18] all keys recalibrate after reset or software reset
// [R19] calibration takes nine complete burst cycles
// [R20] general status byte: any detecting, any calibrating, any error
// [R21] host polls status byte, asks details only when needed
// [R22] drift compensation only while signal has not crossed negative threshold
// [R23] detect sample when signal below reference minus negative threshold
// [R24] global hysteresis 12.5, 25 or 50 percent sets drop-out level
// [R25] negative-delay recalibration loads reference, clears integrator, ends detect
// [R26] delay timers restart from zero when their condition ends early
module tkdr_core #(
  parameter int NK = `TKDR_NUM_KEYS,
  parameter int SW = `TKDR_SIG_W,
  parameter int DW = `TKDR_DELAY_W
) (
  input  wire logic                 mclk,          // 200 MHz clock
  input  wire logic                 reset,         // sync reset, active high
  input  wire logic                 sample_valid,  // one-cycle: new signal for sample_key
  input  wire logic [3:0]           sample_key,    // key index of the sample
  input  wire logic [SW-1:0]        sample_sig,    // measured signal
  input  wire logic                 burst_cycle,   // one-cycle: a full scan ended
  input  wire logic                 drift_up,      // one-cycle: raise reference by one
  input  wire logic                 drift_dn,      // one-cycle: lower reference by one
  input  wire logic [NK*SW-1:0]     neg_thr,       // per-key negative threshold
  input  wire logic [NK*SW-1:0]     pos_thr,       // per-key positive threshold
  input  wire logic [NK*4-1:0]      integ_target,  // per-key integrator target
  input  wire logic [NK*DW-1:0]     neg_delay,     // per-key negative delay, in samples
  input  wire logic [NK*DW-1:0]     pos_delay,     // per-key positive delay, in samples
  input  wire logic [NK-1:0]        supp_en,       // per-key neighbour_suppression enable
  input  wire tkdr_pkg::tkdr_hys_type neg_hys,     // global negative hysteresis
  input  wire tkdr_pkg::tkdr_hys_type pos_hys,     // global positive hysteresis
  input  wire logic [7:0]           gb_pos,        // positive guardband, 0.1 % steps
  input  wire logic [7:0]           gb_neg,        // negative guardband, 0.1 % steps
  input  wire logic                 lock_cmd,      // one-cycle: lock references
  input  wire logic                 recal_cmd,     // one-cycle: full recalibration
  input  wire logic                 recal_all,     // scope: all keys when high
  input  wire logic [3:0]           recal_key,     // scope: single key
  input  wire logic                 soft_reset,    // one-cycle: reset command
  output logic [NK-1:0]             key_state,     // confirmed touches
  output logic [NK-1:0]             key_cal,       // keys calibrating
  output logic [NK-1:0]             err_field,     // multi-key error field
  output logic [NK*4-1:0]           key_err,       // per-key error nibble
  output logic [7:0]                gen_status,    // general status byte
  output logic [NK*SW-1:0]          ref_out        // present references
);
  import tkdr_pkg::*;
  if (NK != 16 || SW < 8 || DW < 1) begin : g_param_chk
    $error("tkdr_core: unsupported parameters");
  end
  logic [SW-1:0] ref_reg   [NK];
  logic [SW-1:0] ref_next  [NK];
  logic [SW-1:0] sig_reg   [NK];
  logic [SW-1:0] sig_next  [NK];
  logic [3:0]    int_reg   [NK];
  logic [3:0]    int_next  [NK];
  logic [DW-1:0] ntim_reg  [NK];
  logic [DW-1:0] ntim_next [NK];
  logic [DW-1:0] ptim_reg  [NK];
  logic [DW-1:0] ptim_next [NK];
  logic [NK-1:0] det_reg, det_next;
  logic [NK-1:0] cal_reg, cal_next;
  logic [NK-1:0] gbp_reg, gbp_next;
  logic [NK-1:0] gbn_reg, gbn_next;
  logic [3:0]    calcnt_reg, calcnt_next;
  logic          locked_reg, locked_next;
  logic [SW-1:0] dev [NK];
  logic [NK-1:0] dev_pos;
  logic [NK-1:0] beaten;
  logic [3:0]    scan_reg, scan_next;
  logic [3:0]    scan_d_reg, scan_d_next;
  logic [SW-1:0] lock_rd;
  logic [3:0]    lock_wa;
  logic          lock_we;
  logic          lock_busy_reg, lock_busy_next;
  logic [3:0]    lock_idx_reg, lock_idx_next;

  // locked reference store, written during the lock sweep
  tkdr_ref_mem #(.WIDTH(SW), .DEPTH(NK)) u_mem (
    .mclk  (mclk),
    .we    (lock_we),
    .waddr (lock_wa),
    .wdata (ref_reg[lock_wa]),
    .raddr (scan_reg),
    .rdata (lock_rd)
  );

  // negative deviation magnitude of each key, zero when positive
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      dev_pos[k] = (sig_reg[k] >= ref_reg[k]);
      dev[k] = dev_pos[k] ? '0 : ref_reg[k] - sig_reg[k];
    end
  end

  // suppression among all enabled keys, no adjacency
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      beaten[k] = 1'b0;
      for (int j = 0; j < NK; j++) begin
        if (j != k && supp_en[j] && supp_en[k] && dev[j] > dev[k]) begin
          beaten[k] = 1'b1; // [R15] [R16]
        end
      end
    end
  end

  // per-key processing
  always_comb begin
    logic [SW-1:0] nt, pt, drop;
    logic [3:0]    tgt;
    logic [DW-1:0] nd, pd;
    logic          hit, rel, above, start_cal;
    nt = '0; pt = '0; drop = '0; tgt = '0; nd = '0; pd = '0;
    hit = 1'b0; rel = 1'b0; above = 1'b0;
    start_cal = soft_reset || (recal_cmd && recal_all); // [R17] [R18]
    cal_next    = cal_reg;
    calcnt_next = calcnt_reg;
    det_next    = det_reg;
    for (int k = 0; k < NK; k++) begin
      ref_next[k]  = ref_reg[k];
      sig_next[k]  = sig_reg[k];
      int_next[k]  = int_reg[k];
      ntim_next[k] = ntim_reg[k];
      ptim_next[k] = ptim_reg[k];
    end
    if (start_cal) begin
      cal_next = '1;
      calcnt_next = '0;
    end else if (recal_cmd) begin
      cal_next[recal_key] = 1'b1; // [R17]
      calcnt_next = '0;
    end else if (|cal_reg && burst_cycle) begin
      if (calcnt_reg == `TKDR_CAL_BURSTS - 4'h1) begin
        cal_next = '0; // [R19]
        calcnt_next = '0;
      end else begin
        calcnt_next = calcnt_reg + 4'h1; // [R19]
      end
    end
    for (int k = 0; k < NK; k++) begin
      nt  = neg_thr[k*SW +: SW];
      pt  = pos_thr[k*SW +: SW];
      tgt = integ_target[k*4 +: 4]; // [R7]
      nd  = neg_delay[k*DW +: DW];
      pd  = pos_delay[k*DW +: DW];
      case (neg_hys)
        tkdr_hys_12p5: drop = nt - (nt >> 3); // [R24]
        tkdr_hys_25:   drop = nt - (nt >> 2); // [R24]
        tkdr_hys_50:   drop = nt - (nt >> 1); // [R24]
        default:       drop = nt;
      endcase
      if (sample_valid && sample_key == 4'(k)) begin
        sig_next[k] = sample_sig;
        if (cal_reg[k]) begin
          ref_next[k] = sample_sig; // calibration tracks signal
          int_next[k] = '0;
          det_next[k] = 1'b0;
          ntim_next[k] = '0;
          ptim_next[k] = '0;
        end else begin
          hit = (sample_sig < ref_reg[k] - nt) && (tgt != 4'h0); // [R23] [R6]
          rel = (sample_sig >= ref_reg[k] - drop); // [R24]
          case (pos_hys)
            tkdr_hys_12p5: above = sample_sig > ref_reg[k] + pt - (pt >> 3);
            tkdr_hys_25:   above = sample_sig > ref_reg[k] + pt - (pt >> 2);
            default:       above = sample_sig > ref_reg[k] + pt - (pt >> 1);
          endcase
          if (!det_reg[k]) begin
            if (hit) begin
              if (int_reg[k] + 4'h1 >= tgt) begin
                int_next[k] = tgt;
                det_next[k] = 1'b1; // [R3]
              end else begin
                int_next[k] = int_reg[k] + 4'h1; // [R3]
              end
            end else if (tgt == 4'h0) begin
              int_next[k] = '0; // [R6]
            end else begin
              int_next[k] = '0; // [R4]
            end
          end else if (rel || tgt == 4'h0) begin
            int_next[k] = (int_reg[k] > 4'h1) ? int_reg[k] - 4'h1 : 4'h0; // [R5]
            det_next[k] = (int_reg[k] > 4'h1) && tgt != 4'h0; // [R5]
          end
          if (det_reg[k] && nd != '0) begin
            if (ntim_reg[k] + DW'(1) >= nd) begin
              ref_next[k]  = sample_sig; // [R1] [R25]
              int_next[k]  = '0; // [R25]
              det_next[k]  = 1'b0; // [R25]
              ntim_next[k] = '0;
            end else begin
              ntim_next[k] = ntim_reg[k] + DW'(1); // [R1] [R2]
            end
          end else begin
            ntim_next[k] = '0; // [R26] [R2]
          end
          if (above && pd != '0) begin
            if (ptim_reg[k] + DW'(1) >= pd) begin
              ref_next[k]  = sample_sig; // [R8]
              ptim_next[k] = '0;
            end else begin
              ptim_next[k] = ptim_reg[k] + DW'(1); // [R8] [R9]
            end
          end else begin
            ptim_next[k] = '0; // [R26] [R9]
          end
        end
      end else if (!det_reg[k] && !cal_reg[k] && sig_reg[k] >= ref_reg[k] - nt) begin
        if (drift_up && sample_key == 4'(k)) begin
          ref_next[k] = ref_reg[k] + SW'(1); // [R22]
        end else if (drift_dn && sample_key == 4'(k)) begin
          ref_next[k] = ref_reg[k] - SW'(1); // [R22]
        end
      end
    end
  end

  // guardband check against the locked reference, one key per cycle
  always_comb begin
    logic [SW+8-1:0] band_p, band_n;
    logic [SW-1:0]   cur;
    band_p = (SW+8)'((SW+8)'(lock_rd) * gb_pos / `TKDR_GB_DIV); // [R11]
    band_n = (SW+8)'((SW+8)'(lock_rd) * gb_neg / `TKDR_GB_DIV); // [R11]
    // the store answers one cycle late, so compare the key it answered for
    cur = ref_reg[scan_d_reg];
    scan_next = scan_reg + 4'h1;
    scan_d_next = scan_reg;
    gbp_next = gbp_reg;
    gbn_next = gbn_reg;
    locked_next = locked_reg || lock_busy_reg;
    lock_busy_next = lock_busy_reg;
    lock_idx_next = lock_idx_reg;
    if (lock_cmd && !lock_busy_reg) begin
      lock_busy_next = 1'b1; // [R10]
      lock_idx_next = '0;
    end else if (lock_busy_reg) begin
      lock_idx_next = lock_idx_reg + 4'h1; // [R10]
      lock_busy_next = (lock_idx_reg != 4'(NK - 1));
    end
    if (locked_reg && !lock_busy_reg) begin
      gbp_next[scan_d_reg] = (gb_pos != 8'h00) &&
        ((SW+8)'(cur) > (SW+8)'(lock_rd) + band_p); // [R12] [R13]
      gbn_next[scan_d_reg] = (gb_neg != 8'h00) &&
        ((SW+8)'(cur) + band_n < (SW+8)'(lock_rd)); // [R12] [R13]
    end
  end
  assign lock_we = lock_busy_reg;
  assign lock_wa = lock_idx_reg;

  // state registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int k = 0; k < NK; k++) begin
        ref_reg[k] <= '0; sig_reg[k] <= '0; int_reg[k] <= '0;
        ntim_reg[k] <= '0; ptim_reg[k] <= '0;
      end
      det_reg <= '0; cal_reg <= '1; calcnt_reg <= '0; // [R18]
      gbp_reg <= '0; gbn_reg <= '0; locked_reg <= 1'b0; scan_reg <= '0; scan_d_reg <= '0;
      lock_busy_reg <= 1'b0; lock_idx_reg <= '0;
    end else begin
      for (int k = 0; k < NK; k++) begin
        ref_reg[k] <= ref_next[k]; sig_reg[k] <= sig_next[k];
        int_reg[k] <= int_next[k]; ntim_reg[k] <= ntim_next[k];
        ptim_reg[k] <= ptim_next[k];
      end
      det_reg <= det_next; cal_reg <= cal_next; calcnt_reg <= calcnt_next;
      gbp_reg <= gbp_next; gbn_reg <= gbn_next; locked_reg <= locked_next;
      scan_reg <= scan_next; lock_busy_reg <= lock_busy_next;
      scan_d_reg <= scan_d_next;
      lock_idx_reg <= lock_idx_next;
    end
  end

  // reporting outputs
  always_comb begin
    for (int k = 0; k < NK; k++) begin
      key_err[k*4 +: 4] = 4'h0;
      key_err[k*4 + `TKDR_ERR_GB_POS] = gbp_reg[k]; // [R13]
      key_err[k*4 + `TKDR_ERR_GB_NEG] = gbn_reg[k]; // [R13]
      ref_out[k*SW +: SW] = ref_reg[k];
    end
    key_state = det_reg & ~(beaten & supp_en); // [R15]
    key_cal = cal_reg;
    err_field = gbp_reg | gbn_reg; // [R14]
    gen_status = 8'h00;
    gen_status[`TKDR_STAT_DETECT] = |key_state; // [R20]
    gen_status[`TKDR_STAT_CAL] = |cal_reg; // [R20]
    gen_status[`TKDR_STAT_ERR] = |err_field; // [R20]
  end

  // checks
  cal_clears_a: assert property (@(posedge mclk) disable iff (reset) // [R19]
    (soft_reset ##1 (!burst_cycle && !recal_cmd && !soft_reset) [*2]) |-> |cal_reg)
    else $error("calibration ended early");
  gb_off_a: assert property (@(posedge mclk) disable iff (reset) // [R12]
    (locked_reg && !lock_busy_reg && gb_pos == 8'h00) |=> !gbp_reg[$past(scan_d_reg)])
    else $error("disabled guardband flagged");
  stat_det_a: assert property (@(posedge mclk) disable iff (reset) // [R20]
    gen_status[`TKDR_STAT_DETECT] == |key_state) else $error("status detect bit wrong");
  stat_cal_a: assert property (@(posedge mclk) disable iff (reset) // [R20]
    (recal_cmd && !soft_reset) |=> gen_status[`TKDR_STAT_CAL])
    else $error("calibration not reported");
  soft_cal_a: assert property (@(posedge mclk) disable iff (reset) // [R18]
    soft_reset |=> &cal_reg) else $error("soft reset missed calibration");
  gb_lock_a: assert property (@(posedge mclk) disable iff (reset) // [R13]
    !locked_reg |-> (err_field == '0)) else $error("error before lock");
  lock_sweep_a: assert property (@(posedge mclk) disable iff (reset) // [R10]
    (lock_cmd && !lock_busy_reg) |=> lock_busy_reg ##16 !lock_busy_reg)
    else $error("lock sweep length wrong");
  supp_off_a: assert property (@(posedge mclk) disable iff (reset) // [R16]
    (supp_en == '0) |-> (key_state == det_reg)) else $error("suppression without enable");
  lock_c: cover property (@(posedge mclk) lock_cmd ##20 |err_field);
  det_c: cover property (@(posedge mclk) |key_state);
  cal_c: cover property (@(posedge mclk) recal_cmd ##1 |cal_reg);
endmodule
`default_nettype wire

// ---- rtl/tkdr_defs.svh ----
// constants for the touch key detect and recalibration block
`ifndef TKDR_DEFS_SVH
`define TKDR_DEFS_SVH
`define TKDR_NUM_KEYS      16
`define TKDR_SIG_W         12
`define TKDR_INTEG_W       4
`define TKDR_DELAY_W       8
`define TKDR_GB_W          8
`define TKDR_CAL_BURSTS    4'h9
`define TKDR_GB_DIV        1000
`define TKDR_ERR_GB_POS    2
`define TKDR_ERR_GB_NEG    3
`define TKDR_STAT_DETECT   0
`define TKDR_STAT_CAL      1
`define TKDR_STAT_ERR      2
`endif

// ---- rtl/tkdr_pkg.sv ----
// types for the touch key detect and recalibration block
`default_nettype none
package tkdr_pkg;
  typedef enum logic [1:0] {tkdr_hys_12p5, tkdr_hys_25, tkdr_hys_50} tkdr_hys_type;
  typedef enum logic [1:0] {tkdr_idle, tkdr_cal, tkdr_run} tkdr_state_type;
endpackage
`default_nettype wire

// ---- rtl/tkdr_ref_mem.sv ----
// locked reference store, one word per key, registered read
`default_nettype none
module tkdr_ref_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic                     mclk,    // clock
  input  wire logic                     we,      // write strobe
  input  wire logic [$clog2(DEPTH)-1:0] waddr,   // write key
  input  wire logic [WIDTH-1:0]         wdata,   // write value
  input  wire logic [$clog2(DEPTH)-1:0] raddr,   // read key
  output logic      [WIDTH-1:0]         rdata    // registered read value
);
  // refuse a store too small to address or with no data bits
  if (DEPTH < 2 || WIDTH < 1) begin : g_param_chk
    $error("tkdr_ref_mem: unsupported parameters");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  // write port and registered read
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
    rdata <= mem_reg[raddr];
  end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking testbench for the touch key detect and recalibration core
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tkdr_pkg::*;
  logic mclk, reset, sample_valid, burst_cycle, drift_up, drift_dn;
  logic lock_cmd, recal_cmd, recal_all, soft_reset;
  logic [3:0]   sample_key, recal_key;
  logic [11:0]  sample_sig;
  logic [191:0] neg_thr, pos_thr, ref_out;
  logic [127:0] neg_delay, pos_delay;
  logic [63:0]  integ_target, key_err;
  logic [15:0]  supp_en, key_state, key_cal, err_field;
  logic [7:0]   gb_pos, gb_neg, gen_status;
  tkdr_hys_type neg_hys, pos_hys;
  int err_count, check_count;
  int cyc = 0;

  tkdr_acq_model tkdr_acq_model_inst (.mclk(mclk), .sample_valid(sample_valid),
    .sample_key(sample_key), .sample_sig(sample_sig), .burst_cycle(burst_cycle),
    .drift_up(drift_up), .drift_dn(drift_dn));
  tkdr_core tkdr_core_inst (.mclk(mclk), .reset(reset), .sample_valid(sample_valid),
    .sample_key(sample_key), .sample_sig(sample_sig), .burst_cycle(burst_cycle),
    .drift_up(drift_up), .drift_dn(drift_dn), .neg_thr(neg_thr), .pos_thr(pos_thr),
    .integ_target(integ_target), .neg_delay(neg_delay), .pos_delay(pos_delay),
    .supp_en(supp_en), .neg_hys(neg_hys), .pos_hys(pos_hys), .gb_pos(gb_pos),
    .gb_neg(gb_neg), .lock_cmd(lock_cmd), .recal_cmd(recal_cmd), .recal_all(recal_all),
    .recal_key(recal_key), .soft_reset(soft_reset), .key_state(key_state),
    .key_cal(key_cal), .err_field(err_field), .key_err(key_err),
    .gen_status(gen_status), .ref_out(ref_out));

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  // compare of flag fields
  task automatic chk_bits(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // compare of one key reference
  task automatic chk_ref(input int k, input logic [11:0] exp);
    check_count++;
    if (ref_out[k*12+:12] !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t ref key %0d got %h exp %h", $time, k, ref_out[k*12+:12], exp);
    end
  endtask
  // n samples of one key
  task automatic s(input int k, input logic [11:0] v, input int n);
    repeat (n) tkdr_acq_model_inst.sample(4'(k), v);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic bursts(input int n);
    repeat (n) tkdr_acq_model_inst.burst();
    wt(1);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well above the expected run of about 650 cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {reset, lock_cmd, recal_cmd, recal_all, soft_reset} = 5'h10;
    recal_key = 4'h0;
    {err_count, check_count} = '0;
    neg_thr = {16{12'h064}};
    pos_thr = {16{12'h032}};
    integ_target = {16{4'h2}};
    {neg_delay, pos_delay, supp_en, gb_pos, gb_neg} = '0;
    neg_hys = tkdr_hys_12p5;
    pos_hys = tkdr_hys_12p5;
    wt(5);
    reset = 1'b0;
    wt(1);
    chk_bits(key_cal, 16'hFFFF, "cal after reset");
    chk_bits({8'h00, gen_status}, 16'h0002, "status");
    for (int k = 0; k < 16; k++) s(k, 12'h7D0, 1);
    bursts(8);
    chk_bits(key_cal, 16'hFFFF, "cal at 8 bursts");
    bursts(1);
    chk_bits(key_cal, 16'h0000, "cal at 9 bursts");
    chk_ref(0, 12'h7D0);
    // integrator confirm, restart and release
    integ_target[3:0] = 4'h3;
    s(0, 12'h708, 2);
    s(0, 12'h7D0, 1);
    s(0, 12'h708, 2);
    chk_bits(key_state, 16'h0000, "integ restart");
    s(0, 12'h708, 1);
    chk_bits(key_state, 16'h0001, "integ confirm");
    chk_bits({8'h00, gen_status}, 16'h0001, "status detect");
    s(0, 12'h7D0, 2);
    chk_bits(key_state, 16'h0001, "release count");
    s(0, 12'h7D0, 1);
    chk_bits(key_state, 16'h0000, "release done");
    // target zero disables, largest target of sixteen
    integ_target[7:4] = 4'h0;
    s(1, 12'h708, 3);
    chk_bits(key_state, 16'h0000, "target zero");
    integ_target[7:4] = 4'hF;
    s(1, 12'h708, 14);
    chk_bits(key_state, 16'h0000, "target 15 early");
    s(1, 12'h708, 1);
    chk_bits(key_state, 16'h0002, "target 15");
    s(1, 12'h7D0, 15);
    chk_bits(key_state, 16'h0000, "target 15 off");
    // negative delay recalibration, enabled and disabled
    integ_target[15:8] = 8'h11;
    neg_delay[23:16] = 8'h04;
    s(2, 12'h708, 1);
    chk_bits(key_state, 16'h0004, "detect");
    s(2, 12'h708, 8);
    chk_bits(key_state, 16'h0000, "neg recal ends detect");
    chk_ref(2, 12'h708);
    s(3, 12'h708, 9);
    chk_bits(key_state, 16'h0008, "neg delay zero");
    tkdr_acq_model_inst.drift(4'h3, 1'b1);
    chk_ref(3, 12'h7D0);
    s(3, 12'h7D0, 1);
    // positive delay recalibration, disabled and restart
    pos_hys = tkdr_hys_25;
    pos_delay[39:32] = 8'h03;
    pos_delay[55:48] = 8'h03;
    s(4, 12'h834, 6);
    chk_ref(4, 12'h834);
    s(5, 12'h834, 6);
    chk_ref(5, 12'h7D0);
    s(6, 12'h834, 2);
    s(6, 12'h7D0, 1);
    s(6, 12'h834, 2);
    chk_ref(6, 12'h7D0);
    tkdr_acq_model_inst.drift(4'hA, 1'b1);
    chk_ref(10, 12'h7D1);
    tkdr_acq_model_inst.drift(4'hA, 1'b0);
    chk_ref(10, 12'h7D0);
    // wide hysteresis holds a detection that the narrow one drops
    neg_hys = tkdr_hys_50;
    s(11, 12'h708, 2);
    s(11, 12'h780, 2);
    chk_bits(key_state, 16'h0800, "hysteresis 50 holds");
    s(11, 12'h79E, 2);
    chk_bits(key_state, 16'h0000, "hysteresis 50 drops");
    // suppression among enabled keys only
    integ_target[39:28] = 12'h111;
    supp_en = 16'h0180;
    s(7, 12'h708, 1);
    s(8, 12'h76A, 1);
    s(9, 12'h6A4, 1);
    chk_bits(key_state, 16'h0280, "suppression");
    s(7, 12'h7D0, 1);
    s(8, 12'h7D0, 1);
    s(9, 12'h7D0, 1);
    // lock then guardband violations, status polled before details
    gb_pos = 8'h64;
    @(negedge mclk) lock_cmd = 1'b1;
    @(negedge mclk) lock_cmd = 1'b0;
    wt(40);
    chk_bits(err_field, 16'h0000, "no error at lock");
    s(4, 12'h960, 6);
    wt(40);
    chk_bits({15'h0000, gen_status[2]}, 16'h0001, "status error");
    chk_bits(err_field, 16'h0010, "error field");
    chk_bits({12'h000, key_err[19:16]}, 16'h0004, "pos band bit");
    s(2, 12'h5DC, 9);
    wt(40);
    chk_bits({12'h000, key_err[11:8]}, 16'h0000, "neg band off");
    gb_neg = 8'h64;
    wt(40);
    chk_bits({12'h000, key_err[11:8]}, 16'h0008, "neg band bit");
    chk_bits(err_field, 16'h0014, "two keys in field");
    gb_pos = 8'h00;
    wt(40);
    chk_bits(err_field, 16'h0004, "pos band off");
    // full recalibration scopes, soft and hard reset
    recal_key = 4'h9;
    @(negedge mclk) recal_cmd = 1'b1;
    @(negedge mclk) recal_cmd = 1'b0;
    chk_bits(key_cal, 16'h0200, "recal one key");
    bursts(9);
    chk_bits(key_cal, 16'h0000, "recal one done");
    recal_all = 1'b1;
    @(negedge mclk) recal_cmd = 1'b1;
    @(negedge mclk) recal_cmd = 1'b0;
    chk_bits(key_cal, 16'hFFFF, "recal all");
    bursts(9);
    @(negedge mclk) soft_reset = 1'b1;
    @(negedge mclk) soft_reset = 1'b0;
    chk_bits(key_cal, 16'hFFFF, "soft reset");
    @(negedge mclk) reset = 1'b1;
    @(negedge mclk) reset = 1'b0;
    wt(1);
    chk_bits(key_cal, 16'hFFFF, "second reset");
    chk_bits(err_field, 16'h0000, "reset clears error");
    finish_test();
  end
endmodule
`default_nettype wire

// ---- tb/tkdr_acq_model.sv ----
// acquisition front-end model that feeds key samples and scan-end strobes
`default_nettype none
module tkdr_acq_model (
  input  wire logic        mclk,          // clock
  output logic             sample_valid,  // sample strobe
  output logic [3:0]       sample_key,    // sampled key
  output logic [11:0]      sample_sig,    // measured signal
  output logic             burst_cycle,   // scan end strobe
  output logic             drift_up,      // raise reference strobe
  output logic             drift_dn       // lower reference strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle values before the first request
  initial begin
    sample_valid = 1'b0;
    sample_key   = 4'h0;
    sample_sig   = 12'h000;
    burst_cycle  = 1'b0;
    drift_up     = 1'b0;
    drift_dn     = 1'b0;
  end

  // one sample, then scrambled data so a stale value is never reused
  task automatic sample(input logic [3:0] k, input logic [11:0] v);
    @(negedge mclk);
    sample_key   = k;
    sample_sig   = v;
    sample_valid = 1'b1;
    @(negedge mclk);
    sample_valid = 1'b0;
    sample_sig   = ~v;
    @(negedge mclk);
  endtask

  // end of one full scan
  task automatic burst();
    @(negedge mclk);
    burst_cycle = 1'b1;
    @(negedge mclk);
    burst_cycle = 1'b0;
  endtask

  // single drift step for one key, upward or downward
  task automatic drift(input logic [3:0] k, input logic up);
    @(negedge mclk);
    sample_key = k;
    drift_up   = up;
    drift_dn   = !up;
    @(negedge mclk);
    drift_up = 1'b0;
    drift_dn = 1'b0;
    @(negedge mclk);
  endtask
endmodule
`default_nettype wire
